// ### rtl/awd_defines.svh
// Offsets, field positions, reset values and limits of the window decoder
`ifndef AWD_DEFINES_SVH
`define AWD_DEFINES_SVH

// Register placement and reset value
`define AWD_MAP_OFFSET   6'h10
`define AWD_MAP_RESET    16'h0000

// Base/size format fields
`define AWD_RSV_ZERO_BIT 15
`define AWD_EN_BIT       14
`define AWD_DIR_BIT      13
`define AWD_ONES_HI      12
`define AWD_ONES_LO      11
`define AWD_SIZE_HI      10
`define AWD_SIZE_LO      8
`define AWD_BASE_HI      7
`define AWD_BASE_LO      0

// Bound format fields
`define AWD_UPPER_HI     15
`define AWD_UPPER_LO     8
`define AWD_LOWER_HI     7
`define AWD_LOWER_LO     0

// Byte lanes of the register port
`define AWD_LANE_LOWER   0
`define AWD_LANE_UPPER   1

// Compared address slice and the equal-bounds split point
`define AWD_CMP_HI       31
`define AWD_CMP_LO       24
`define AWD_ALL_OUT_MIN  8'h80

`endif

// ### rtl/awd_pkg.sv
// Types shared by the address window decoder
package awd_pkg;

   // Interpretation of the map register
   typedef enum logic {
      AWD_FMT_BASE_SIZE,
      AWD_FMT_BOUND
   } awd_fmt_e;

   // Forwarding decision for both directions
   typedef struct packed {
      logic fwd_out;
      logic fwd_in;
   } awd_route_s;

endpackage : awd_pkg

// ### rtl/awd_size_match.sv
// Base/size comparison of the upper address byte against the window base
`timescale 1ns/10ps
module awd_size_match #(
   parameter int FIELD_W = 8
) (
   // Window fields
   input  wire logic [2:0]         size,
   input  wire logic [FIELD_W-1:0] base,
   // Address slice under test
   input  wire logic [FIELD_W-1:0] addr_hi,
   // Result
   output wire logic               match
);

   logic [FIELD_W-1:0] diff;

   // A bit counts only while its rank from the top is below the size
   genvar k;
   generate
      for (k = 0; k < FIELD_W; k = k + 1)
      begin : g_bit
         localparam logic [2:0] RANK = 3'(FIELD_W - 1 - k);
         assign diff[k] = (addr_hi[k] ^ base[k]) & (RANK < size);
      end
   endgenerate

   // Size zero masks every bit, so every address matches
   assign match = ~|diff;

endmodule : awd_size_match

// ### rtl/awd_bound_match.sv
// Upper/lower bound comparison of the upper address byte
`timescale 1ns/10ps
module awd_bound_match #(
   parameter int FIELD_W = 8
) (
   // Bound fields
   input  wire logic [FIELD_W-1:0] upper,
   input  wire logic [FIELD_W-1:0] lower,
   // Address slice under test
   input  wire logic [FIELD_W-1:0] addr_hi,
   // Address lies in the inward range
   output wire logic               inward
);

   logic at_or_above_lower;
   logic below_upper;

   // Raw comparisons
   assign at_or_above_lower = (addr_hi >= lower);
   assign below_upper       = (addr_hi < upper);

   // Swapped bounds wrap the range around, giving the inverted window
   assign inward = (lower < upper) ? (at_or_above_lower & below_upper)
                                   : (at_or_above_lower | below_upper);

endmodule : awd_bound_match

// ### rtl/awd_window_decoder.sv
// 32-bit address window decoder with its map register
// How it works
// - Map register at 0x10, cleared on reset
// - Select bit chooses base/size or bound format
// - Base format: bit15 zero, bits12-11 ones
// - Bit 14 enables window; clear disables
// - Bit 13 picks inward or outward cycles
// - Outside range maps the opposite direction
// - Size field counts compared base bits
// - Only top size base bits are compared
// - Bound format: upper and lower byte fields
// - Outward at or above upper, below lower
// - Swapped bounds map a range outward
// - Both bounds zero disables the window
// - Equal bounds 80..FF send all outward
// - Equal bounds 01..7F send all inward
// - Window armed only after lower byte write
`timescale 1ns/10ps
`include "awd_defines.svh"
module awd_window_decoder #(
   parameter int ADDR_W = 32,
   parameter int DATA_W = 16
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              sys_rst,
   // Format select from the control register
   input  wire logic              range_compare_select,
   // Backplane register port
   input  wire logic              reg_sel,
   input  wire logic [5:0]        reg_offset,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   input  wire logic [1:0]        reg_be,
   input  wire logic [DATA_W-1:0] reg_wdata,
   output wire logic [DATA_W-1:0] reg_rdata,
   output wire logic              reg_ack,
   // Backplane cycle offered for outward forwarding
   input  wire logic              out_req_valid,
   input  wire logic [ADDR_W-1:0] out_req_addr,
   output wire logic              out_done,
   output wire logic              out_fwd,
   // Cable cycle offered for inward forwarding
   input  wire logic              in_req_valid,
   input  wire logic [ADDR_W-1:0] in_req_addr,
   output wire logic              in_done,
   output wire logic              in_fwd,
   // Window state
   output wire logic              window_active
);

   awd_pkg::awd_fmt_e   fmt;
   logic [DATA_W-1:0]   map_ff;
   logic [DATA_W-1:0]   nxt_map;
   logic                armed_ff;
   logic                nxt_armed;
   logic [DATA_W-1:0]   reg_rdata_ff;
   logic [DATA_W-1:0]   nxt_reg_rdata;
   logic                reg_ack_ff;
   logic                nxt_reg_ack;
   logic                out_done_ff;
   logic                nxt_out_done;
   logic                out_fwd_ff;
   logic                nxt_out_fwd;
   logic                in_done_ff;
   logic                nxt_in_done;
   logic                in_fwd_ff;
   logic                nxt_in_fwd;
   logic                active_ff;
   logic                nxt_active;
   logic                map_hit;
   logic                map_write;
   logic                out_bs_hit;
   logic                in_bs_hit;
   logic                out_bd_in;
   logic                in_bd_in;
   logic [7:0]          upper_f;
   logic [7:0]          lower_f;
   awd_pkg::awd_route_s out_route;
   awd_pkg::awd_route_s in_route;

   // Format follows the control bit, base/size when it is low
   assign fmt = range_compare_select ? awd_pkg::AWD_FMT_BOUND
                                     : awd_pkg::AWD_FMT_BASE_SIZE;

   // Field views of the stored register
   assign upper_f   = map_ff[`AWD_UPPER_HI:`AWD_UPPER_LO];
   assign lower_f   = map_ff[`AWD_LOWER_HI:`AWD_LOWER_LO];
   assign map_hit   = reg_sel && (reg_offset == `AWD_MAP_OFFSET);
   assign map_write = map_hit && reg_wr;

   // Read view: base/size format forces the reserved pattern
   function automatic logic [DATA_W-1:0] read_view(
      input logic [DATA_W-1:0] map,
      input awd_pkg::awd_fmt_e f
   );
      logic [DATA_W-1:0] v;
      v = map;
      if (f == awd_pkg::AWD_FMT_BASE_SIZE)
      begin
         v[`AWD_RSV_ZERO_BIT]         = 1'b0;
         v[`AWD_ONES_HI:`AWD_ONES_LO] = 2'b11;
      end
      return v;
   endfunction : read_view

   // Routing of one address; used for both directions
   function automatic awd_pkg::awd_route_s route(
      input awd_pkg::awd_fmt_e f,
      input logic [DATA_W-1:0] map,
      input logic              armed,
      input logic              bs_hit,
      input logic              bd_in
   );
      awd_pkg::awd_route_s r;
      logic [7:0]          hi;
      logic [7:0]          lo;
      hi = map[`AWD_UPPER_HI:`AWD_UPPER_LO];
      lo = map[`AWD_LOWER_HI:`AWD_LOWER_LO];
      r  = '0;
      if (!armed)
      begin
         r = '0;
      end
      else if (f == awd_pkg::AWD_FMT_BASE_SIZE)
      begin
         if (!map[`AWD_EN_BIT])
         begin
            r = '0;
         end
         else if (map[`AWD_DIR_BIT])
         begin
            // Window selects inward, the rest goes outward
            r.fwd_in  = bs_hit;
            r.fwd_out = !bs_hit;
         end
         else
         begin
            r.fwd_out = bs_hit;
            r.fwd_in  = !bs_hit;
         end
      end
      else if ((hi == 8'h00) && (lo == 8'h00))
      begin
         r = '0;
      end
      else if (hi == lo)
      begin
         r.fwd_out = (hi >= `AWD_ALL_OUT_MIN);
         r.fwd_in  = (hi < `AWD_ALL_OUT_MIN);
      end
      else
      begin
         r.fwd_in  = bd_in;
         r.fwd_out = !bd_in;
      end
      return r;
   endfunction : route

   // Comparators, one set per direction since both may be busy at once
   awd_size_match #(
      .FIELD_W (8)
   ) u_out_size (
      .size    (map_ff[`AWD_SIZE_HI:`AWD_SIZE_LO]),
      .base    (map_ff[`AWD_BASE_HI:`AWD_BASE_LO]),
      .addr_hi (out_req_addr[`AWD_CMP_HI:`AWD_CMP_LO]),
      .match   (out_bs_hit)
   );

   awd_size_match #(
      .FIELD_W (8)
   ) u_in_size (
      .size    (map_ff[`AWD_SIZE_HI:`AWD_SIZE_LO]),
      .base    (map_ff[`AWD_BASE_HI:`AWD_BASE_LO]),
      .addr_hi (in_req_addr[`AWD_CMP_HI:`AWD_CMP_LO]),
      .match   (in_bs_hit)
   );

   awd_bound_match #(
      .FIELD_W (8)
   ) u_out_bound (
      .upper   (upper_f),
      .lower   (lower_f),
      .addr_hi (out_req_addr[`AWD_CMP_HI:`AWD_CMP_LO]),
      .inward  (out_bd_in)
   );

   awd_bound_match #(
      .FIELD_W (8)
   ) u_in_bound (
      .upper   (upper_f),
      .lower   (lower_f),
      .addr_hi (in_req_addr[`AWD_CMP_HI:`AWD_CMP_LO]),
      .inward  (in_bd_in)
   );

   assign out_route = route(fmt, map_ff, armed_ff, out_bs_hit, out_bd_in);
   assign in_route  = route(fmt, map_ff, armed_ff, in_bs_hit, in_bd_in);

   // Register file next state; lower byte write arms, upper alone disarms
   always_comb
   begin
      nxt_map       = map_ff;
      nxt_armed     = armed_ff;
      nxt_reg_rdata = reg_rdata_ff;
      nxt_reg_ack   = reg_sel && (reg_wr || reg_rd);
      if (map_write && reg_be[`AWD_LANE_UPPER])
      begin
         nxt_map[15:8] = reg_wdata[15:8];
         nxt_armed     = 1'b0;
      end
      if (map_write && reg_be[`AWD_LANE_LOWER])
      begin
         nxt_map[7:0] = reg_wdata[7:0];
         nxt_armed    = 1'b1;
      end
      if (reg_sel && reg_rd)
      begin
         // Unmapped offsets read as zero
         nxt_reg_rdata = map_hit ? read_view(map_ff, fmt) : '0;
      end
   end

   // Register file flops
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         map_ff       <= `AWD_MAP_RESET;
         armed_ff     <= 1'b0;
         reg_rdata_ff <= 16'h0000;
         reg_ack_ff   <= 1'b0;
      end
      else
      begin
         map_ff       <= nxt_map;
         armed_ff     <= nxt_armed;
         reg_rdata_ff <= nxt_reg_rdata;
         reg_ack_ff   <= nxt_reg_ack;
      end
   end

   // Decision next state; a result is held until the next request
   always_comb
   begin
      nxt_out_done = out_req_valid;
      nxt_in_done  = in_req_valid;
      nxt_out_fwd  = out_req_valid ? out_route.fwd_out : out_fwd_ff;
      nxt_in_fwd   = in_req_valid ? in_route.fwd_in : in_fwd_ff;
      nxt_active   = armed_ff &&
                     ((fmt == awd_pkg::AWD_FMT_BOUND) ? (map_ff != 16'h0000)
                                                      : map_ff[`AWD_EN_BIT]);
   end

   // Decision flops
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         out_done_ff <= 1'b0;
         out_fwd_ff  <= 1'b0;
         in_done_ff  <= 1'b0;
         in_fwd_ff   <= 1'b0;
         active_ff   <= 1'b0;
      end
      else
      begin
         out_done_ff <= nxt_out_done;
         out_fwd_ff  <= nxt_out_fwd;
         in_done_ff  <= nxt_in_done;
         in_fwd_ff   <= nxt_in_fwd;
         active_ff   <= nxt_active;
      end
   end

   // Outputs straight from flops
   assign reg_rdata     = reg_rdata_ff;
   assign reg_ack       = reg_ack_ff;
   assign out_done      = out_done_ff;
   assign out_fwd       = out_fwd_ff;
   assign in_done       = in_done_ff;
   assign in_fwd        = in_fwd_ff;
   assign window_active = active_ff;

   // Full write lands whole in the register
   property p_full_write;
      @(posedge clk) disable iff (sys_rst)
      (map_write && reg_be == 2'b11) |=> (map_ff == $past(reg_wdata));
   endproperty
   a_full_write: assert property (p_full_write)
      else $error("map register did not take a full write");

   // Base/size read shows the fixed reserved pattern
   property p_base_view;
      @(posedge clk) disable iff (sys_rst)
      (map_hit && reg_rd && !range_compare_select)
      |=> (reg_ack && !reg_rdata[15] && reg_rdata[12:11] == 2'b11);
   endproperty
   a_base_view: assert property (p_base_view)
      else $error("reserved bits read wrong in base/size format");

   // Disabled base window forwards nothing outward
   property p_base_off;
      @(posedge clk) disable iff (sys_rst)
      (!range_compare_select && !map_ff[`AWD_EN_BIT] && out_req_valid)
      |=> (out_done && !out_fwd);
   endproperty
   a_base_off: assert property (p_base_off)
      else $error("disabled window forwarded a cycle outward");

   // Outward window forwards exactly the matching addresses
   property p_dir_out;
      @(posedge clk) disable iff (sys_rst)
      (!range_compare_select && armed_ff && map_ff[14:13] == 2'b10
       && out_req_valid) |=> (out_fwd == $past(out_bs_hit));
   endproperty
   a_dir_out: assert property (p_dir_out)
      else $error("outward window decision wrong");

   // Inward window sends the complement outward
   property p_opposite;
      @(posedge clk) disable iff (sys_rst)
      (!range_compare_select && armed_ff && map_ff[14:13] == 2'b11
       && out_req_valid) |=> (out_fwd == !$past(out_bs_hit));
   endproperty
   a_opposite: assert property (p_opposite)
      else $error("complement not mapped the opposite way");

   // Size zero window matches everything
   property p_size_zero;
      @(posedge clk) disable iff (sys_rst)
      (!range_compare_select && armed_ff && map_ff[14:13] == 2'b10
       && map_ff[10:8] == 3'h0 && out_req_valid) |=> out_fwd;
   endproperty
   a_size_zero: assert property (p_size_zero)
      else $error("size zero window missed an address");

   // In-range bound address goes inward
   property p_bound_in;
      @(posedge clk) disable iff (sys_rst)
      (range_compare_select && armed_ff && lower_f < upper_f && in_req_valid
       && in_req_addr[31:24] >= lower_f && in_req_addr[31:24] < upper_f)
      |=> in_fwd;
   endproperty
   a_bound_in: assert property (p_bound_in)
      else $error("in-range address not mapped inward");

   // Zero bounds forward nothing in either direction
   property p_bound_zero;
      @(posedge clk) disable iff (sys_rst)
      (range_compare_select && map_ff == 16'h0000 && in_req_valid
       && out_req_valid) |=> (!in_fwd && !out_fwd && in_done && out_done);
   endproperty
   a_bound_zero: assert property (p_bound_zero)
      else $error("zero bounds did not disable the window");

   // Equal high bounds send all outward
   property p_all_out;
      @(posedge clk) disable iff (sys_rst)
      (range_compare_select && armed_ff && upper_f == lower_f
       && upper_f >= 8'h80 && out_req_valid && in_req_valid)
      |=> (out_fwd && !in_fwd);
   endproperty
   a_all_out: assert property (p_all_out)
      else $error("equal bounds at or above 80 not all outward");

   // Equal low nonzero bounds send all inward
   property p_all_in;
      @(posedge clk) disable iff (sys_rst)
      (range_compare_select && armed_ff && upper_f == lower_f
       && upper_f != 8'h00 && upper_f < 8'h80 && out_req_valid
       && in_req_valid) |=> (in_fwd && !out_fwd);
   endproperty
   a_all_in: assert property (p_all_in)
      else $error("equal bounds below 80 not all inward");

   // Upper byte alone disarms and keeps the window off until lower byte
   property p_arm;
      @(posedge clk) disable iff (sys_rst)
      (map_write && reg_be == 2'b10) |=> (!armed_ff ##1 !window_active);
   endproperty
   a_arm: assert property (p_arm)
      else $error("window armed before its lower byte was written");

endmodule : awd_window_decoder

// ### bench/awd_cycle_agent.sv
// Far-side agent offering one cycle at a time to both decision ports
`timescale 1ns/10ps
module awd_cycle_agent (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Command from the bench
   input  wire logic        start,
   input  wire logic [31:0] addr,
   // Requests toward the decoder
   output logic             out_req_valid,
   output logic [31:0]      out_req_addr,
   output logic             in_req_valid,
   output logic [31:0]      in_req_addr,
   // Decoder answers
   input  wire logic        out_done,
   input  wire logic        out_fwd,
   input  wire logic        in_done,
   input  wire logic        in_fwd,
   // Captured decision
   output logic             got_out,
   output logic             got_in,
   output logic             seen
);

   // One-cycle request; idle address toggles so stale values never match
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         out_req_valid <= 1'b0;
         in_req_valid  <= 1'b0;
         out_req_addr  <= 32'hffff_ffff;
         in_req_addr   <= 32'hffff_ffff;
      end
      else if (start)
      begin
         out_req_valid <= 1'b1;
         in_req_valid  <= 1'b1;
         out_req_addr  <= addr;
         in_req_addr   <= addr;
      end
      else
      begin
         out_req_valid <= 1'b0;
         in_req_valid  <= 1'b0;
         out_req_addr  <= ~out_req_addr;
         in_req_addr   <= ~in_req_addr;
      end
   end

   // Decision is taken only in the cycle that both done pulses stand
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         got_out <= 1'b0;
         got_in  <= 1'b0;
         seen    <= 1'b0;
      end
      else if (out_done && in_done)
      begin
         got_out <= out_fwd;
         got_in  <= in_fwd;
         seen    <= 1'b1;
      end
      else if (start)
         seen <= 1'b0;
   end

endmodule : awd_cycle_agent

// ### bench/test_a32_address_window_decoder.sv
// Self-checking bench for the 32-bit address window decoder
`timescale 1ns/10ps
module test_a32_address_window_decoder;
   typedef struct packed {
      logic        cm;
      logic [15:0] map;
      logic [7:0]  a;
      logic        o;
      logic        i;
   } awd_row_s;
   // Format, register value, address byte, expected out and in
   localparam awd_row_s ROWS [19] = '{
   '{1'b0, 16'h41c8, 8'h80, 1'b1, 1'b0}, '{1'b0, 16'h41c8, 8'h7f, 1'b0, 1'b1},
   '{1'b0, 16'h6349, 8'h5f, 1'b0, 1'b1}, '{1'b0, 16'h6349, 8'h60, 1'b1, 1'b0},
   '{1'b0, 16'h40ff, 8'h00, 1'b1, 1'b0}, '{1'b0, 16'h4719, 8'h18, 1'b1, 1'b0},
   '{1'b0, 16'h4719, 8'h1a, 1'b0, 1'b1}, '{1'b0, 16'h21c8, 8'h80, 1'b0, 1'b0},
   '{1'b1, 16'h5020, 8'h20, 1'b0, 1'b1}, '{1'b1, 16'h5020, 8'h50, 1'b1, 1'b0},
   '{1'b1, 16'h5020, 8'h1f, 1'b1, 1'b0}, '{1'b1, 16'h2050, 8'h30, 1'b1, 1'b0},
   '{1'b1, 16'h2050, 8'h50, 1'b0, 1'b1}, '{1'b1, 16'h2050, 8'h1f, 1'b0, 1'b1},
   '{1'b1, 16'h0000, 8'h40, 1'b0, 1'b0}, '{1'b1, 16'h8080, 8'h00, 1'b1, 1'b0},
   '{1'b1, 16'hffff, 8'h7f, 1'b1, 1'b0}, '{1'b1, 16'h7f7f, 8'hff, 1'b0, 1'b1},
   '{1'b1, 16'h0101, 8'h00, 1'b0, 1'b1}};
   localparam int CEIL = 4000;

   logic        clk;
   logic        sys_rst;
   logic        range_compare_select;
   logic        reg_sel;
   logic [5:0]  reg_offset;
   logic        reg_wr;
   logic        reg_rd;
   logic [1:0]  reg_be;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;
   logic        reg_ack;
   logic        out_req_valid;
   logic [31:0] out_req_addr;
   logic        out_done;
   logic        out_fwd;
   logic        in_req_valid;
   logic [31:0] in_req_addr;
   logic        in_done;
   logic        in_fwd;
   logic        window_active;
   logic        start;
   logic [31:0] addr;
   logic        got_out;
   logic        got_in;
   logic        seen;
   logic [15:0] rd;
   logic [15:0] exp_view;
   logic [15:0] exp_act;
   int          n_fail;
   int          samples_checked;
   int          cycles;

   awd_window_decoder dut (
      .clk(clk), .sys_rst(sys_rst),
      .range_compare_select(range_compare_select),
      .reg_sel(reg_sel), .reg_offset(reg_offset), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_be(reg_be), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_ack(reg_ack),
      .out_req_valid(out_req_valid), .out_req_addr(out_req_addr),
      .out_done(out_done), .out_fwd(out_fwd),
      .in_req_valid(in_req_valid), .in_req_addr(in_req_addr),
      .in_done(in_done), .in_fwd(in_fwd), .window_active(window_active));

   awd_cycle_agent agent (
      .clk(clk), .sys_rst(sys_rst), .start(start), .addr(addr),
      .out_req_valid(out_req_valid), .out_req_addr(out_req_addr),
      .in_req_valid(in_req_valid), .in_req_addr(in_req_addr),
      .out_done(out_done), .out_fwd(out_fwd), .in_done(in_done),
      .in_fwd(in_fwd), .got_out(got_out), .got_in(got_in), .seen(seen));

   // Free-running 250 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic check(input string nm, input logic [15:0] got,
                        input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : check

   task summarize;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : summarize

   // One-cycle strobe; ack is looked at in the cycle it stands
   task automatic reg_access(input logic wr, input logic [5:0] off,
                             input logic [1:0] be, input logic [15:0] d);
      @(posedge clk);
      reg_sel    <= 1'b1;
      reg_wr     <= wr;
      reg_rd     <= ~wr;
      reg_offset <= off;
      reg_be     <= be;
      reg_wdata  <= d;
      @(posedge clk);
      reg_sel <= 1'b0;
      reg_wr  <= 1'b0;
      reg_rd  <= 1'b0;
      #1;
      check("reg_ack", reg_ack, 16'h0001);
      rd = reg_rdata;
   endtask : reg_access

   // Offer one address to both directions and compare the decision
   task automatic probe(input logic [7:0] a, input logic o, input logic i);
      int n;
      @(posedge clk);
      start <= 1'b1;
      addr  <= {a, 24'h00a5c3};
      @(posedge clk);
      start <= 1'b0;
      n = 0;
      do
      begin
         @(posedge clk);
         #1;
         n++;
      end
      while (seen !== 1'b1 && n < 8);
      check("seen", seen, 16'h0001);
      check("out_fwd", got_out, o);
      check("in_fwd", got_in, i);
      // Done pulses stand one cycle only
      check("done_low", {14'h0000, out_done, in_done}, 16'h0000);
   endtask : probe

   // Bound on the whole run in case a handshake hangs
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == CEIL)
      begin
         n_fail++;
         summarize();
      end
   end

   initial
   begin
      n_fail = 0;
      samples_checked = 0;
      cycles = 0;
      sys_rst = 1'b1;
      range_compare_select = 1'b0;
      reg_sel = 1'b0;
      reg_offset = 6'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_be = 2'h0;
      reg_wdata = 16'h0000;
      start = 1'b0;
      addr = 32'h0000_0000;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      // Reset value seen through the base/size view
      reg_access(1'b0, 6'h10, 2'h3, 16'h0000);
      check("map_reset", rd, 16'h1800);
      probe(8'h80, 1'b0, 1'b0);
      // Table cases: full-width write, read view, then decision
      foreach (ROWS[k])
      begin
         @(posedge clk);
         range_compare_select <= ROWS[k].cm;
         reg_access(1'b1, 6'h10, 2'h3, ROWS[k].map);
         reg_access(1'b0, 6'h10, 2'h3, 16'h0000);
         exp_view = ROWS[k].cm ? ROWS[k].map
                  : {1'b0, ROWS[k].map[14:13], 2'b11, ROWS[k].map[10:0]};
         exp_act  = ROWS[k].cm ? 16'(ROWS[k].map != 16'h0000)
                  : 16'(ROWS[k].map[14]);
         check("map_view", rd, exp_view);
         check("active", window_active, exp_act);
         probe(ROWS[k].a, ROWS[k].o, ROWS[k].i);
      end
      // Same value read in bound format, then decided in base/size format
      reg_access(1'b0, 6'h10, 2'h3, 16'h0000);
      check("bound_view", rd, 16'h0101);
      @(posedge clk);
      range_compare_select <= 1'b0;
      probe(8'h00, 1'b0, 1'b0);
      // Byte-wide update: upper byte alone leaves the window off
      reg_access(1'b1, 6'h10, 2'h2, 16'h4100);
      probe(8'h80, 1'b0, 1'b0);
      check("active_upper", window_active, 16'h0000);
      reg_access(1'b1, 6'h10, 2'h1, 16'h00c8);
      probe(8'h80, 1'b1, 1'b0);
      check("active_lower", window_active, 16'h0001);
      // Unmapped offset: write ignored, read gives zero
      reg_access(1'b1, 6'h12, 2'h3, 16'hffff);
      reg_access(1'b0, 6'h12, 2'h3, 16'h0000);
      check("unmapped", rd, 16'h0000);
      reg_access(1'b0, 6'h10, 2'h3, 16'h0000);
      check("map_kept", rd, 16'h59c8);
      // Reset in mid-run clears the register and disarms the window
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      #1;
      check("active_rst", window_active, 16'h0000);
      reg_access(1'b0, 6'h10, 2'h3, 16'h0000);
      check("map_rst", rd, 16'h1800);
      probe(8'h80, 1'b0, 1'b0);
      summarize();
   end

endmodule : test_a32_address_window_decoder
